// ==== shared/tdc_pkg.sv ====
// Shared constants, field layouts and carrier types of the transmit descriptor word-0 logic
`default_nettype none

package tdc_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Descriptor word 0 bit positions
    localparam int unsigned TDC_W0_LAST_SEG    = 29;
    localparam int unsigned TDC_W0_END_OF_RING = 21;
    localparam int unsigned TDC_W0_CHAINED     = 20;
    localparam int unsigned TDC_W0_RSVD_HI     = 19;
    localparam int unsigned TDC_W0_RSVD_LO     = 18;
    localparam int unsigned TDC_W0_TS_STATUS   = 17;
    localparam int unsigned TDC_W0_IP_HDR_ERR  = 16;

    // Descriptor word 1 buffer size fields
    localparam int unsigned TDC_SIZE_W         = 13;
    localparam int unsigned TDC_W1_BUF1_LO     = 0;
    localparam int unsigned TDC_W1_BUF2_LO     = 16;

    // Sequential descriptors are four words apart
    localparam logic [31:0] TDC_DESC_BYTES     = 32'h0000_0010;

    ////////////////////////////////////////////////////////////////////////////////
    // Header check constants
    localparam logic [15:0] TDC_ETH_TYPE_IPV4  = 16'h0800;
    localparam logic [15:0] TDC_ETH_TYPE_IPV6  = 16'h86dd;
    localparam logic [3:0]  TDC_IP_VER_4       = 4'h4;
    localparam logic [3:0]  TDC_IP_VER_6       = 4'h6;
    localparam logic [3:0]  TDC_IPV4_MIN_IHL   = 4'h5;
    localparam logic [7:0]  TDC_IPV6_HDR_BYTES = 8'h28;

    ////////////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [7:0]  TDC_REG_CTRL       = 8'h00;
    localparam logic [7:0]  TDC_REG_LIST_BASE  = 8'h04;
    localparam logic [7:0]  TDC_REG_CUR_DESC   = 8'h08;
    localparam logic [7:0]  TDC_REG_IRQ_STATUS = 8'h0c;
    localparam logic [7:0]  TDC_REG_IRQ_CLEAR  = 8'h10;
    localparam logic [7:0]  TDC_REG_IRQ_ENABLE = 8'h14;

    localparam int unsigned TDC_CTRL_OFFLOAD_EN = 0;

    // Interrupt status bits
    localparam int unsigned TDC_IRQ_W          = 3;
    localparam int unsigned TDC_IRQ_RING_WRAP  = 0;
    localparam int unsigned TDC_IRQ_HDR_ERR    = 1;
    localparam int unsigned TDC_IRQ_TS_CAPT    = 2;

    ////////////////////////////////////////////////////////////////////////////////
    // Carrier types
    typedef struct packed {
        logic [31:0] w3;
        logic [31:0] w2;
        logic [31:0] w1;
        logic [31:0] w0;
    } tdc_desc_t;

    typedef struct packed {
        logic [15:0] eth_type;
        logic [3:0]  ip_version;
        logic [3:0]  ihl;
        logic [7:0]  hdr_bytes;
    } tdc_hdr_t;

    typedef struct packed {
        logic        ts_captured;
        logic [63:0] timestamp;
    } tdc_frame_t;

    typedef struct packed {
        logic [31:0]         buf1_addr;
        logic [TDC_SIZE_W-1:0] buf1_size;
        logic                buf2_used;
        logic [31:0]         buf2_addr;
        logic [TDC_SIZE_W-1:0] buf2_size;
    } tdc_buf_t;

    // Sticky set wins over a same-cycle clear
    function automatic logic [TDC_IRQ_W-1:0] tdc_sticky(input logic [TDC_IRQ_W-1:0] cur,
                                                       input logic [TDC_IRQ_W-1:0] clr,
                                                       input logic [TDC_IRQ_W-1:0] set);
        tdc_sticky = (cur & ~clr) | set;
    endfunction

    // Size field of word 1 starting at a given bit
    function automatic logic [TDC_SIZE_W-1:0] tdc_size(input logic [31:0] w,
                                                      input int unsigned lo);
        tdc_size = w[lo +: TDC_SIZE_W];
    endfunction

endpackage

`default_nettype wire

// ==== verilog/tdc_next_addr.sv ====
// Next-descriptor address and buffer selection for one fetched transmit descriptor
`default_nettype none

module tdc_next_addr
    import tdc_pkg::*;
(
    input  wire logic      clk_sys_in,
    input  wire logic      resetn_in,
    input  wire logic      valid_in,
    input  wire tdc_desc_t desc_in,
    input  wire logic [31:0] cur_addr_in,
    input  wire logic [31:0] base_addr_in,
    output logic           valid_out,
    output logic           wrapped_out,
    output logic [31:0]    next_addr_out,
    output tdc_buf_t       buf_out
);

    typedef struct packed {
        logic        valid;
        logic        wrapped;
        logic [31:0] next_addr;
        tdc_buf_t    bufs;
    } tdc_na_state_t;

    tdc_na_state_t s_q;
    tdc_na_state_t s_d;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        s_d       = s_q;
        s_d.valid = valid_in;
        if (valid_in)
        begin
            s_d.wrapped        = 1'b0;
            s_d.bufs.buf1_addr = desc_in.w2;
            s_d.bufs.buf1_size = tdc_size(desc_in.w1, TDC_W1_BUF1_LO);
            if (desc_in.w0[TDC_W0_END_OF_RING])
            begin
                // End of ring beats chaining
                s_d.next_addr = base_addr_in;
                s_d.wrapped   = 1'b1;
            end
            else if (desc_in.w0[TDC_W0_CHAINED])
            begin
                s_d.next_addr = desc_in.w3;
            end
            else
            begin
                s_d.next_addr = cur_addr_in + TDC_DESC_BYTES;
            end
            if (desc_in.w0[TDC_W0_CHAINED])
            begin
                // Word 3 is a pointer here, and the second size is not looked at
                s_d.bufs.buf2_used = 1'b0;
                s_d.bufs.buf2_addr = 32'h0000_0000;
                s_d.bufs.buf2_size = '0;
            end
            else
            begin
                s_d.bufs.buf2_used = 1'b1;
                s_d.bufs.buf2_addr = desc_in.w3;
                s_d.bufs.buf2_size = tdc_size(desc_in.w1, TDC_W1_BUF2_LO);
            end
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign valid_out     = s_q.valid;
    assign wrapped_out   = s_q.wrapped;
    assign next_addr_out = s_q.next_addr;
    assign buf_out       = s_q.bufs;

endmodule // tdc_next_addr

`default_nettype wire

// ==== verilog/tdc_ip_check.sv ====
// IP header consistency check done by the transmit checksum offload engine
`default_nettype none

module tdc_ip_check
    import tdc_pkg::*;
(
    input  wire logic     clk_sys_in,
    input  wire logic     resetn_in,
    input  wire logic     check_in,
    input  wire tdc_hdr_t hdr_in,
    output logic          done_out,
    output logic          hdr_err_out,
    output logic          is_ipv4_out
);

    typedef struct packed {
        logic done;
        logic err;
        logic v4;
    } tdc_ic_state_t;

    tdc_ic_state_t s_q;
    tdc_ic_state_t s_d;
    logic          type_v4;
    logic          type_v6;
    logic [7:0]    ihl_bytes;

    ////////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        type_v4   = (hdr_in.eth_type == TDC_ETH_TYPE_IPV4);
        type_v6   = (hdr_in.eth_type == TDC_ETH_TYPE_IPV6);
        ihl_bytes = {2'b00, hdr_in.ihl, 2'b00};
        s_d       = s_q;
        s_d.done  = check_in;
        if (check_in)
        begin
            s_d.v4  = type_v4;
            s_d.err = 1'b0;
            if (type_v4)
            begin
                if (hdr_in.ip_version != TDC_IP_VER_4)
                    s_d.err = 1'b1;
                if (ihl_bytes != hdr_in.hdr_bytes)
                    s_d.err = 1'b1;
                if (hdr_in.ihl < TDC_IPV4_MIN_IHL)
                    s_d.err = 1'b1;
            end
            else if (type_v6)
            begin
                if (hdr_in.ip_version != TDC_IP_VER_6)
                    s_d.err = 1'b1;
                if (hdr_in.hdr_bytes != TDC_IPV6_HDR_BYTES)
                    s_d.err = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    assign done_out    = s_q.done;
    assign hdr_err_out = s_q.err;
    assign is_ipv4_out = s_q.v4;

endmodule // tdc_ip_check

`default_nettype wire

// ==== verilog/tdc_word0_ctrl.sv ====
// Transmit descriptor word-0 control and status handling with register port and interrupt
//
// Functional notes
// - End-of-ring sends next fetch to base.
// - Chained bit makes word 3 next pointer.
// - Second buffer size ignored while chained.
// - End-of-ring wins over chained pointer.
// - Timestamp bit set, timestamp into words 2-3.
// - Timestamp bit only in last-segment descriptors.
// - IPv4 header length must match byte count.
// - IPv6 main header must be forty bytes.
// - Length/Type must match IP version.
// - IPv4 header length below five is error.
// - Header error needs offload; IPv4 checksum still inserted.
//
// Chosen here: the register addresses and strobed register access.
`default_nettype none

module tdc_word0_ctrl
    import tdc_pkg::*;
(
    input  wire logic        clk_sys_in,
    input  wire logic        resetn_in,
    // Register port
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic [31:0] reg_wdata_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    output logic [31:0]      reg_rdata_out,
    // Descriptor fetch
    input  wire logic        fetch_valid_in,
    input  wire tdc_desc_t   fetch_desc_in,
    output logic             desc_valid_out,
    output logic [31:0]      cur_desc_addr_out,
    output tdc_buf_t         buf_out,
    // Frame completion
    input  wire logic        frame_done_in,
    input  wire tdc_frame_t  frame_in,
    input  wire tdc_hdr_t    hdr_in,
    output logic             csum_insert_v4_out,
    output logic             wb_valid_out,
    output logic [31:0]      wb_word0_out,
    output logic [31:0]      wb_word2_out,
    output logic [31:0]      wb_word3_out,
    // Interrupt
    output logic             irq_out
);

    typedef struct packed {
        logic                 offload_en;
        logic [31:0]          list_base;
        logic [31:0]          cur_desc;
        logic [TDC_IRQ_W-1:0] irq_status;
        logic [TDC_IRQ_W-1:0] irq_enable;
        logic [31:0]          rdata;
        logic                 irq;
        tdc_desc_t            held;
        tdc_frame_t           frame;
        logic                 desc_valid;
        tdc_buf_t             bufs;
        logic                 csum_v4;
        logic                 wb_valid;
        logic [31:0]          wb_w0;
        logic [31:0]          wb_w2;
        logic [31:0]          wb_w3;
    } tdc_state_t;

    tdc_state_t s_q;
    tdc_state_t s_d;

    logic        na_valid;
    logic        na_wrapped;
    logic [31:0] na_next;
    tdc_buf_t    na_buf;
    logic        ic_done;
    logic        ic_err;
    logic        ic_v4;

    ////////////////////////////////////////////////////////////////////////////////
    // Sub-blocks

    tdc_next_addr u_next_addr
    (
        .clk_sys_in    (clk_sys_in),
        .resetn_in     (resetn_in),
        .valid_in      (fetch_valid_in),
        .desc_in       (fetch_desc_in),
        .cur_addr_in   (s_q.cur_desc),
        .base_addr_in  (s_q.list_base),
        .valid_out     (na_valid),
        .wrapped_out   (na_wrapped),
        .next_addr_out (na_next),
        .buf_out       (na_buf)
    );

    tdc_ip_check u_ip_check
    (
        .clk_sys_in  (clk_sys_in),
        .resetn_in   (resetn_in),
        .check_in    (frame_done_in),
        .hdr_in      (hdr_in),
        .done_out    (ic_done),
        .hdr_err_out (ic_err),
        .is_ipv4_out (ic_v4)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    logic [TDC_IRQ_W-1:0] ev_set;
    logic [TDC_IRQ_W-1:0] ev_clr;
    logic                 ts_ok;
    logic                 err_ok;

    always_comb
    begin
        s_d    = s_q;
        ev_set = '0;
        ev_clr = '0;
        ts_ok  = 1'b0;
        err_ok = 1'b0;

        // Read data stand for one cycle only
        s_d.rdata = 32'h0000_0000;
        if (reg_rd_in)
        begin
            unique case (reg_addr_in)
                TDC_REG_CTRL:
                    s_d.rdata[TDC_CTRL_OFFLOAD_EN] = s_q.offload_en;
                TDC_REG_LIST_BASE:
                    s_d.rdata = s_q.list_base;
                TDC_REG_CUR_DESC:
                    s_d.rdata = s_q.cur_desc;
                TDC_REG_IRQ_STATUS:
                    s_d.rdata[TDC_IRQ_W-1:0] = s_q.irq_status;
                TDC_REG_IRQ_ENABLE:
                    s_d.rdata[TDC_IRQ_W-1:0] = s_q.irq_enable;
                default:
                    s_d.rdata = 32'h0000_0000;
            endcase
        end

        if (reg_wr_in)
        begin
            unique case (reg_addr_in)
                TDC_REG_CTRL:
                    s_d.offload_en = reg_wdata_in[TDC_CTRL_OFFLOAD_EN];
                TDC_REG_LIST_BASE:
                begin
                    // Reprogramming the base restarts the walk from the top of the list
                    s_d.list_base = reg_wdata_in;
                    s_d.cur_desc  = reg_wdata_in;
                end
                TDC_REG_IRQ_CLEAR:
                    ev_clr = reg_wdata_in[TDC_IRQ_W-1:0];
                TDC_REG_IRQ_ENABLE:
                    s_d.irq_enable = reg_wdata_in[TDC_IRQ_W-1:0];
                default:
                    ev_clr = '0;
            endcase
        end

        // Fetch: keep the whole descriptor for the later write-back
        if (fetch_valid_in)
            s_d.held = fetch_desc_in;

        s_d.desc_valid = na_valid;
        if (na_valid)
        begin
            // A base write in the same cycle loses to the walk it just raced
            s_d.cur_desc = na_next;
            s_d.bufs     = na_buf;
            ev_set[TDC_IRQ_RING_WRAP] = na_wrapped;
        end

        // Completion: timestamp held until the header check answers
        if (frame_done_in)
            s_d.frame = frame_in;

        s_d.wb_valid = ic_done;
        if (ic_done)
        begin
            ts_ok  = s_q.frame.ts_captured && s_q.held.w0[TDC_W0_LAST_SEG];
            err_ok = ic_err && s_q.offload_en;
            // Only bits 17 and 16 change; everything else, reserved included, goes back
            s_d.wb_w0 = s_q.held.w0;
            s_d.wb_w0[TDC_W0_TS_STATUS]  = ts_ok;
            s_d.wb_w0[TDC_W0_IP_HDR_ERR] = err_ok;
            if (ts_ok)
            begin
                s_d.wb_w2 = s_q.frame.timestamp[31:0];
                s_d.wb_w3 = s_q.frame.timestamp[63:32];
            end
            else
            begin
                s_d.wb_w2 = s_q.held.w2;
                s_d.wb_w3 = s_q.held.w3;
            end
            // Checksum still inserted for IPv4 even with a header error
            s_d.csum_v4 = s_q.offload_en && ic_v4;
            ev_set[TDC_IRQ_HDR_ERR] = err_ok;
            ev_set[TDC_IRQ_TS_CAPT] = ts_ok;
        end

        s_d.irq_status = tdc_sticky(s_q.irq_status, ev_clr, ev_set);
        s_d.irq        = |(s_d.irq_status & s_d.irq_enable);
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
            s_q <= '0;
        else
            s_q <= s_d;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign reg_rdata_out      = s_q.rdata;
    assign desc_valid_out     = s_q.desc_valid;
    assign cur_desc_addr_out  = s_q.cur_desc;
    assign buf_out            = s_q.bufs;
    assign csum_insert_v4_out = s_q.csum_v4;
    assign wb_valid_out       = s_q.wb_valid;
    assign wb_word0_out       = s_q.wb_w0;
    assign wb_word2_out       = s_q.wb_w2;
    assign wb_word3_out       = s_q.wb_w3;
    assign irq_out            = s_q.irq;

endmodule // tdc_word0_ctrl

`default_nettype wire

// ==== tb/tdc_word0_assertions.sv ====
// Port-level checker for the transmit descriptor word-0 block
`default_nettype none
module tdc_word0_assertions
    import tdc_pkg::*;
(
    input wire logic        clk_sys_in,
    input wire logic        resetn_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic        reg_wr_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        fetch_valid_in,
    input wire tdc_desc_t   fetch_desc_in,
    input wire logic        desc_valid_out,
    input wire logic [31:0] cur_desc_addr_out,
    input wire tdc_buf_t    buf_out,
    input wire logic        frame_done_in,
    input wire tdc_frame_t  frame_in,
    input wire tdc_hdr_t    hdr_in,
    input wire logic        csum_insert_v4_out,
    input wire logic        wb_valid_out,
    input wire logic [31:0] wb_word0_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] base_q;
    logic        off_q;
    logic        ls_q;
    logic [1:0]  rsvd_q;
    logic        v4_t;
    logic        herr;
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!resetn_in);
    // Mirrors of the state the answers depend on
    always_ff @(posedge clk_sys_in)
    begin
        if (!resetn_in)
        begin
            base_q <= '0;
            off_q  <= 1'b0;
            ls_q   <= 1'b0;
            rsvd_q <= '0;
        end
        else
        begin
            if (reg_wr_in && reg_addr_in == TDC_REG_LIST_BASE)
                base_q <= reg_wdata_in;
            if (reg_wr_in && reg_addr_in == TDC_REG_CTRL)
                off_q <= reg_wdata_in[0];
            if (fetch_valid_in)
                ls_q <= fetch_desc_in.w0[29];
            if (fetch_valid_in)
                rsvd_q <= fetch_desc_in.w0[19:18];
        end
    end
    assign v4_t = hdr_in.eth_type == TDC_ETH_TYPE_IPV4;
    assign herr = (v4_t && (hdr_in.ip_version != 4'h4 || hdr_in.ihl < 4'h5
                  || {2'h0, hdr_in.ihl, 2'h0} != hdr_in.hdr_bytes))
               || (hdr_in.eth_type == TDC_ETH_TYPE_IPV6
                  && (hdr_in.ip_version != 4'h6 || hdr_in.hdr_bytes != 8'h28));
    ////////////////////////////////////////
    a_rdata_idle:
        assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
        else $error("read data not zero outside read answer");
    a_desc_latency:
        assert property (fetch_valid_in |-> ##2 desc_valid_out)
        else $error("descriptor answer missing");
    a_wb_latency:
        assert property (frame_done_in |=> ##1 wb_valid_out)
        else $error("write-back answer missing");
    a_ring_base:
        assert property (fetch_valid_in && fetch_desc_in.w0[21]
                         |-> ##2 cur_desc_addr_out == $past(base_q, 2))
        else $error("end of ring did not return to base");
    a_chain_next:
        assert property (fetch_valid_in && fetch_desc_in.w0[20] && !fetch_desc_in.w0[21]
                         |-> ##2 cur_desc_addr_out == $past(fetch_desc_in.w3, 2))
        else $error("chained pointer not followed");
    a_seq_next:
        assert property (fetch_valid_in && fetch_desc_in.w0[21:20] == 2'b00
                         |-> ##2 cur_desc_addr_out == $past(cur_desc_addr_out, 2) + 32'h10)
        else $error("sequential next address wrong");
    a_chain_buf2:
        assert property (fetch_valid_in && fetch_desc_in.w0[20]
                         |-> ##2 buf_out.buf2_size == 13'h0 && !buf_out.buf2_used)
        else $error("second buffer used while chained");
    a_rsvd_kept:
        assert property (frame_done_in |-> ##2 wb_word0_out[19:18] == $past(rsvd_q, 2))
        else $error("reserved bits altered");
    a_ts_gate:
        assert property (frame_done_in |-> ##2 wb_word0_out[17]
                         == ($past(frame_in.ts_captured, 2) && $past(ls_q, 2)))
        else $error("timestamp status wrong");
    a_hdr_err:
        assert property (frame_done_in |-> ##2 wb_word0_out[16]
                         == ($past(herr, 2) && $past(off_q, 2)))
        else $error("header error status wrong");
    a_csum_v4:
        assert property (frame_done_in |-> ##2 csum_insert_v4_out
                         == ($past(v4_t, 2) && $past(off_q, 2)))
        else $error("checksum insert flag wrong");
    c_both_ctrl: cover property (fetch_valid_in && fetch_desc_in.w0[21:20] == 2'b11);
    c_hdr_err:   cover property (wb_valid_out && wb_word0_out[16]);
    c_ts_set:    cover property (wb_valid_out && wb_word0_out[17]);
endmodule // tdc_word0_assertions

bind tdc_word0_ctrl tdc_word0_assertions u_chk (
    .clk_sys_in        (clk_sys_in),
    .resetn_in         (resetn_in),
    .reg_addr_in       (reg_addr_in),
    .reg_wdata_in      (reg_wdata_in),
    .reg_wr_in         (reg_wr_in),
    .reg_rd_in         (reg_rd_in),
    .reg_rdata_out     (reg_rdata_out),
    .fetch_valid_in    (fetch_valid_in),
    .fetch_desc_in     (fetch_desc_in),
    .desc_valid_out    (desc_valid_out),
    .cur_desc_addr_out (cur_desc_addr_out),
    .buf_out           (buf_out),
    .frame_done_in     (frame_done_in),
    .frame_in          (frame_in),
    .hdr_in            (hdr_in),
    .csum_insert_v4_out(csum_insert_v4_out),
    .wb_valid_out      (wb_valid_out),
    .wb_word0_out      (wb_word0_out)
);
`default_nettype wire

// ==== tb/tdc_host_model.sv ====
// Host descriptor ring in system memory, looked up by descriptor address
`default_nettype none
module tdc_host_model
    import tdc_pkg::*;
#(
    parameter logic [31:0] RING_BASE = 32'h0000_1000
)
(
    input  wire logic [31:0] addr_in,
    output tdc_desc_t        desc_out
);
    timeunit 1ns;
    timeprecision 1ps;
    tdc_desc_t mem [4];
    // Walk: 0 sequential, 1 chained to 3, 3 closes the ring; reserved bits set to catch damage
    initial
    begin
        mem[0] = '{32'h0000_0b00, 32'h0000_0a00, 32'h0155_0040, 32'h200c_0000};
        mem[1] = '{RING_BASE + 32'h30, 32'h0000_0c00, 32'h0fff_0123, 32'h0014_0000};
        mem[2] = '{32'h0, 32'h0, 32'h0, 32'h0};
        mem[3] = '{32'h0000_2000, 32'h0000_0d00, 32'h0001_0010, 32'h2038_0000};
    end
    assign desc_out = mem[addr_in[5:4]];
endmodule // tdc_host_model
`default_nettype wire

// ==== tb/tdc_word0_ctrl_tb_top.sv ====
// Self-checking bench for the transmit descriptor word-0 block
`default_nettype none
module tdc_word0_ctrl_tb_top
    import tdc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [31:0] RING = 32'h0000_1000;
    logic        clk_sys_in = 1'b0;
    logic        resetn_in = 1'b0;
    logic [7:0]  reg_addr_in = '0;
    logic [31:0] reg_wdata_in = '0;
    logic        reg_wr_in = 1'b0;
    logic        reg_rd_in = 1'b0;
    logic        fetch_valid_in = 1'b0;
    logic        frame_done_in = 1'b0;
    tdc_desc_t   fetch_desc_in = '0;
    tdc_frame_t  frame_in = '0;
    tdc_hdr_t    hdr_in = '0;
    logic [31:0] reg_rdata_out, cur_desc_addr_out, wb_word0_out, wb_word2_out, wb_word3_out;
    logic        desc_valid_out, csum_insert_v4_out, wb_valid_out, irq_out, off;
    logic [2:0]  st, en;
    tdc_buf_t    buf_out;
    tdc_desc_t   host_desc, dsc;
    int          bad_count = 0, n_tests = 0, seed = 87748;
    // Header cases and the error each one must raise
    tdc_hdr_t    hc [8] = '{'{16'h0800, 4'h4, 4'h5, 8'h14}, '{16'h0800, 4'h4, 4'h6, 8'h14},
                           '{16'h0800, 4'h4, 4'h4, 8'h10}, '{16'h86dd, 4'h6, 4'h0, 8'h28},
                           '{16'h86dd, 4'h6, 4'h0, 8'h29}, '{16'h0800, 4'h6, 4'h5, 8'h14},
                           '{16'h86dd, 4'h4, 4'h5, 8'h14}, '{16'h0806, 4'h4, 4'h1, 8'h03}};
    logic [7:0]  herr_exp = 8'b0111_0110;
    logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h3c};
    always #10 clk_sys_in = ~clk_sys_in;
    tdc_word0_ctrl u_dut (
        .clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .fetch_valid_in(fetch_valid_in),
        .fetch_desc_in(fetch_desc_in), .desc_valid_out(desc_valid_out),
        .cur_desc_addr_out(cur_desc_addr_out), .buf_out(buf_out),
        .frame_done_in(frame_done_in), .frame_in(frame_in), .hdr_in(hdr_in),
        .csum_insert_v4_out(csum_insert_v4_out), .wb_valid_out(wb_valid_out),
        .wb_word0_out(wb_word0_out), .wb_word2_out(wb_word2_out),
        .wb_word3_out(wb_word3_out), .irq_out(irq_out));
    tdc_host_model #(.RING_BASE(RING)) u_host (.addr_in(cur_desc_addr_out), .desc_out(host_desc));
    ////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            bad_count++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        @(posedge clk_sys_in);
        reg_rd_in <= 1'b0;
        #1;
        chk(reg_rdata_out, e);
    endtask
    task automatic fetch_one();
        logic [31:0] cur;
        dsc = host_desc;
        cur = cur_desc_addr_out;
        @(posedge clk_sys_in);
        fetch_valid_in <= 1'b1;
        fetch_desc_in <= dsc;
        @(posedge clk_sys_in);
        fetch_valid_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        chk(desc_valid_out, 1'b1);
        chk(cur_desc_addr_out, dsc.w0[21] ? RING : dsc.w0[20] ? dsc.w3 : cur + 32'h10);
        chk({buf_out.buf1_size, buf_out.buf1_addr}, {dsc.w1[12:0], dsc.w2});
        chk({buf_out.buf2_used, buf_out.buf2_addr}, dsc.w0[20] ? 33'h0 : {1'b1, dsc.w3});
        chk(buf_out.buf2_size, dsc.w0[20] ? 13'h0 : dsc.w1[28:16]);
        st[0] = st[0] | dsc.w0[21];
    endtask
    task automatic frame_one(input int k);
        tdc_frame_t  f;
        logic        ts;
        logic [31:0] e0;
        f.ts_captured = 1'($random(seed));
        f.timestamp = {$random(seed), $random(seed)};
        @(posedge clk_sys_in);
        frame_done_in <= 1'b1;
        frame_in <= f;
        hdr_in <= hc[k];
        @(posedge clk_sys_in);
        frame_done_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        ts = f.ts_captured && dsc.w0[29];
        e0 = dsc.w0;
        e0[17] = ts;
        e0[16] = herr_exp[k] && off;
        chk(wb_valid_out, 1'b1);
        chk(wb_word0_out, e0);
        chk(wb_word2_out, ts ? f.timestamp[31:0] : dsc.w2);
        chk(wb_word3_out, ts ? f.timestamp[63:32] : dsc.w3);
        chk(csum_insert_v4_out, off && hc[k].eth_type == 16'h0800);
        st = st | {ts, e0[16], 1'b0};
        @(posedge clk_sys_in);
        #1;
        chk(irq_out, |(st & en));
    endtask
    task automatic test_done();
        $display("comparisons=%0d mismatches=%0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_sys_in);
        bad_count++;
        test_done();
    end
    initial
    begin
        st = '0;
        en = '0;
        off = 1'b0;
        repeat (3) @(posedge clk_sys_in);
        resetn_in <= 1'b1;
        foreach (ra[i])
            reg_rd(ra[i], 32'h0);
        reg_wr(TDC_REG_LIST_BASE, RING);
        reg_wr(TDC_REG_CUR_DESC, 32'h0000_5550);
        reg_rd(TDC_REG_CUR_DESC, RING);
        reg_wr(TDC_REG_IRQ_STATUS, 32'h7);
        reg_rd(TDC_REG_IRQ_STATUS, 32'h0);
        reg_wr(TDC_REG_IRQ_ENABLE, 32'h7);
        reg_rd(TDC_REG_IRQ_CLEAR, 32'h0);
        reg_wr(TDC_REG_CTRL, 32'h1);
        en = 3'h7;
        off = 1'b1;
        for (int i = 0; i < 16; i++)
        begin
            if (i == 8)
                off = 1'b0;
            if (i == 12)
                en = 3'h0;
            reg_wr(TDC_REG_CTRL, {31'h0, off});
            reg_wr(TDC_REG_IRQ_ENABLE, {29'h0, en});
            fetch_one();
            frame_one(i % 8);
            reg_rd(TDC_REG_IRQ_STATUS, {29'h0, st});
            reg_wr(TDC_REG_IRQ_CLEAR, 32'h7);
            st = '0;
            @(posedge clk_sys_in);
            #1;
            chk(irq_out, 1'b0);
        end
        test_done();
    end
endmodule // tdc_word0_ctrl_tb_top
`default_nettype wire
